// >>> rtl/onoff_switch_params.svh
// Purpose: constants for the on/off switch cycle controller
// Assumes: 20 MHz system clock
// Notes: times in their own unit, counts derived
`ifndef ONOFF_SWITCH_PARAMS_SVH
`define ONOFF_SWITCH_PARAMS_SVH
`define CLK_HZ 20000000
`define OSC_BASE_HZ 264000
`define OSC_PERIOD_CYC (`CLK_HZ / `OSC_BASE_HZ)
`define JITTER_PCT 3
`define JITTER_RATE_HZ 1000
`define JITTER_PERIOD_CYC (`CLK_HZ / `JITTER_RATE_HZ)
`define JITTER_SPAN_CYC ((`OSC_PERIOD_CYC * `JITTER_PCT) / 100)
`define MAXDUTY_PCT 65
`define MAXDUTY_CYC ((`OSC_PERIOD_CYC * `MAXDUTY_PCT) / 100)
`define BLANK_NS 200
`define BLANK_CYC ((`BLANK_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define RESTART_ON_CYCLES 8192
`define RESTART_OFF_MS 1000
`define RESTART_OFF_CYC (`CLK_HZ / 1000 * `RESTART_OFF_MS)
`define LEVELS 4
`define HIST_LEN 8
`define STEP_UP_HITS 6
`define STEP_DOWN_HITS 2
`endif

// >>> rtl/onoff_switch_pkg.sv
// Purpose: types for the on/off switch cycle controller
// Assumes: nothing
// Notes: current-limit level travels as a small struct
package onoff_switch_pkg;
	typedef enum logic [1:0] {LVL_MIN, LVL_LOW, LVL_MID, LVL_MAX} limit_level_t;
	typedef struct packed {
		limit_level_t level;
		logic freqDouble;
	} limit_sel_t;
	typedef enum {ST_RUN, ST_RESTART_OFF} restart_state_t;
endpackage : onoff_switch_pkg

// >>> rtl/cycle_oscillator.sv
// Purpose: cycle-start pulse and max-duty window with jitter
// Assumes: one clock, enable pulses only
// Notes: half rate takes every second base period
`include "onoff_switch_params.svh"
module cycle_oscillator (
	input wire logic clk,
	input wire logic rstSync_b,
	input wire logic freqDouble,
	output logic sampleTick,
	output logic cycleStart,
	output logic maxDutyWindow
);
	logic [9:0] phase_r;
	logic [9:0] periodLen;
	logic [19:0] jitCnt_r;
	logic jitDir_r;
	logic [6:0] jitOff_r;
	logic half_r;
	// ===========================================
	// jitter: triangle offset, full sweep every 10 steps of 1666 clocks (about 1.2 kHz)
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			jitCnt_r <= 20'h0;
			jitDir_r <= 1'b0;
			jitOff_r <= 7'h0;
		end else if (jitCnt_r == 20'((`JITTER_PERIOD_CYC / (4 * `JITTER_SPAN_CYC + 4)) - 1)) begin
			jitCnt_r <= 20'h0;
			if (jitDir_r) begin
				if (jitOff_r == 7'h0) jitDir_r <= 1'b0;
				else jitOff_r <= jitOff_r - 7'h1;
			end else begin
				if (jitOff_r == 7'(2 * `JITTER_SPAN_CYC)) jitDir_r <= 1'b1;
				else jitOff_r <= jitOff_r + 7'h1;
			end
		end else begin
			jitCnt_r <= jitCnt_r + 20'h1;
		end
	end
	// period swings plus/minus span around nominal
	assign periodLen = 10'(`OSC_PERIOD_CYC - `JITTER_SPAN_CYC) + 10'(jitOff_r);
	// ===========================================
	// base-rate phase counter
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			phase_r <= 10'h0;
			half_r <= 1'b0;
		end else if (phase_r >= periodLen - 10'h1) begin
			phase_r <= 10'h0;
			// a skipped cycle keeps the next base period a start
			half_r <= !freqDouble && !half_r;
		end else begin
			phase_r <= phase_r + 10'h1;
		end
	end
	assign sampleTick = (phase_r == 10'h0);
	// standard rate is half of peak rate
	assign cycleStart = sampleTick && (freqDouble || !half_r);
	assign maxDutyWindow = (phase_r < 10'(`MAXDUTY_CYC)) && (freqDouble || !half_r);
endmodule : cycle_oscillator

// >>> rtl/onoff_switch_cycle_controller.sv
// Purpose: digital core of an on/off regulated off-line switch
// Assumes: comparator and sense levels arrive synchronous to clk
// Notes: level stepping thresholds live in the params header
// Contract
// - oscillator averages 264 kHz at top level
// - period jitters about 3 percent at 1 kHz; code sweeps at about 1.2 kHz
// - sample enable at cycle start, gate on
// - ignore enable changes within a started cycle
// - keep sampling at 264 kHz while skipping
// - enable history steps current limit level
// - over-limit turns switch off for cycle
// - blank current comparator after turn-on
// - supply lockout below 4.9 until 5.85
// - thermal lockout with hysteresis
// - restart counter cleared by low enable
// - 8192 cycles unregulated stops switching 1 s
// - line undervoltage halts restart off counter
// - extension keeps switch on until limit
// - extension off at start and after restart
// - start only with line sense above threshold
// - ignore line undervoltage once switching enabled
// - absent line resistor disables undervoltage check
// - top level doubles oscillator frequency
// - on at cycle start, off at limit
`include "onoff_switch_params.svh"
module onoff_switch_cycle_controller #(
	parameter int RESTART_OFF_CYCLES = `RESTART_OFF_CYC,
	parameter int LEVEL_COUNT = `LEVELS,
	parameter int UP_HITS = `STEP_UP_HITS,
	parameter int DOWN_HITS = `STEP_DOWN_HITS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enableLineSensePin,
	input wire logic switchOverLimit,
	input wire logic supplyBelowLow,
	input wire logic supplyAboveHigh,
	input wire logic tempAboveTrip,
	input wire logic tempBelowRelease,
	input wire logic lineSenseAboveStart,
	input wire logic lineResistorAbsent,
	output logic powerSwitchGate,
	output onoff_switch_pkg::limit_sel_t limitSel,
	output logic freqDoubleReq,
	output logic maxDutyWindow,
	output logic autoRestartOff
);
	logic rstMeta_r;
	logic rstSync_b;
	logic sampleTick;
	logic cycleStart;
	logic gate_r;
	logic [3:0] blank_r;
	logic supplyLock_r;
	logic thermLock_r;
	logic lineOk_r;
	logic extArmed_r;
	logic [`HIST_LEN-1:0] hist_r;
	logic [1:0] level_r;
	logic [13:0] unregCnt_r;
	logic [31:0] offCnt_r;
	onoff_switch_pkg::restart_state_t rstState_r;
	logic runAllowed;
	logic lineGate;
	logic skip_r;
	function automatic logic [3:0] countOnes(input logic [`HIST_LEN-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < `HIST_LEN; i++) n = n + 4'(v[i]);
		return n;
	endfunction : countOnes
	// ===========================================
	// reset release synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_r <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_b <= rstMeta_r;
		end
	end
	// ===========================================
	// oscillator
	cycle_oscillator oscInst (
		.clk(clk),
		.rstSync_b(rstSync_b),
		.freqDouble(freqDoubleReq || skip_r),
		.sampleTick(sampleTick),
		.cycleStart(cycleStart),
		.maxDutyWindow(maxDutyWindow)
	);
	// a disabled cycle lets the very next base tick start one, so skipping samples at the top rate
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) skip_r <= 1'b0;
		else if (cycleStart) skip_r <= !enableLineSensePin;
	end
	// ===========================================
	// supply and thermal lockouts
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) supplyLock_r <= 1'b1;
		else if (supplyBelowLow) supplyLock_r <= 1'b1;
		else if (supplyAboveHigh) supplyLock_r <= 1'b0;
	end
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) thermLock_r <= 1'b0;
		else if (tempAboveTrip) thermLock_r <= 1'b1;
		else if (tempBelowRelease) thermLock_r <= 1'b0;
	end
	// ===========================================
	// line undervoltage gate: latched on the first good line sense, cleared again in restart off
	assign lineGate = lineSenseAboveStart || lineResistorAbsent;
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) lineOk_r <= 1'b0;
		else if (rstState_r == onoff_switch_pkg::ST_RESTART_OFF) lineOk_r <= 1'b0;
		else if (lineGate) lineOk_r <= 1'b1;
	end
	assign runAllowed = !supplyLock_r && !thermLock_r && lineOk_r &&
		(rstState_r == onoff_switch_pkg::ST_RUN);
	// ===========================================
	// auto-restart
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			rstState_r <= onoff_switch_pkg::ST_RUN;
			unregCnt_r <= 14'h0;
			offCnt_r <= 32'h0;
		end else begin
			unique case (rstState_r)
				onoff_switch_pkg::ST_RUN: begin
					if (sampleTick && !enableLineSensePin) begin
						unregCnt_r <= 14'h0;
					end else if (cycleStart && runAllowed) begin
						if (unregCnt_r == 14'(`RESTART_ON_CYCLES - 1)) begin
							unregCnt_r <= 14'h0;
							offCnt_r <= 32'h0;
							rstState_r <= onoff_switch_pkg::ST_RESTART_OFF;
						end else begin
							unregCnt_r <= unregCnt_r + 14'h1;
						end
					end
				end
				onoff_switch_pkg::ST_RESTART_OFF: begin
					if (!lineGate) begin
						offCnt_r <= offCnt_r;
					end else if (offCnt_r >= 32'(RESTART_OFF_CYCLES - 1)) begin
						rstState_r <= onoff_switch_pkg::ST_RUN;
					end else begin
						offCnt_r <= offCnt_r + 32'h1;
					end
				end
			endcase
		end
	end
	assign autoRestartOff = (rstState_r == onoff_switch_pkg::ST_RESTART_OFF);
	// ===========================================
	// on-time extension arming
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) extArmed_r <= 1'b0;
		else if (autoRestartOff) extArmed_r <= 1'b0;
		else if (sampleTick && runAllowed && !enableLineSensePin) extArmed_r <= 1'b1;
	end
	// ===========================================
	// current limit state machine from enable history
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			// history starts full so the top reset level is not stepped down at once
			hist_r <= '1;
			level_r <= 2'(LEVEL_COUNT - 1);
		end else if (cycleStart) begin
			hist_r <= {hist_r[`HIST_LEN-2:0], enableLineSensePin};
			if (countOnes(hist_r) >= 4'(UP_HITS) && level_r != 2'(LEVEL_COUNT - 1)) begin
				level_r <= level_r + 2'h1;
			end else if (countOnes(hist_r) <= 4'(DOWN_HITS) && level_r != 2'h0) begin
				level_r <= level_r - 2'h1;
			end
		end
	end
	assign freqDoubleReq = (level_r == 2'(LEVEL_COUNT - 1));
	assign limitSel.level = onoff_switch_pkg::limit_level_t'(level_r);
	assign limitSel.freqDouble = freqDoubleReq;
	// ===========================================
	// gate drive with blanking
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			gate_r <= 1'b0;
			blank_r <= 4'h0;
		end else if (!runAllowed || supplyBelowLow || tempAboveTrip) begin
			// raw lockout inputs cut the gate without waiting for the lock flags
			gate_r <= 1'b0;
			blank_r <= 4'h0;
		end else if (cycleStart) begin
			// sampled once; the rest of the cycle ignores the pin
			gate_r <= enableLineSensePin;
			blank_r <= 4'(`BLANK_CYC);
		end else if (gate_r) begin
			if (blank_r != 4'h0) blank_r <= blank_r - 4'h1;
			else if (switchOverLimit) gate_r <= 1'b0;
			if (!maxDutyWindow && !extArmed_r) gate_r <= 1'b0;
		end
	end
	assign powerSwitchGate = gate_r;
endmodule : onoff_switch_cycle_controller

// >>> dv/onoff_switch_sva.sv
// Purpose: port checks for the switch cycle controller
// Assumes: one clock, active low reset
// Notes: bound onto every controller instance
// ====
// checker
module onoff_switch_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enableLineSensePin,
	input wire logic switchOverLimit,
	input wire logic supplyBelowLow,
	input wire logic tempAboveTrip,
	input wire logic powerSwitchGate,
	input wire onoff_switch_pkg::limit_sel_t limitSel,
	input wire logic freqDoubleReq,
	input wire logic maxDutyWindow,
	input wire logic autoRestartOff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_supply_lock: assert property (supplyBelowLow |=> !powerSwitchGate)
		else $error("gate on in supply lock");
	chk_heat_lock: assert property (tempAboveTrip |=> !powerSwitchGate)
		else $error("gate on when hot");
	chk_restart_off: assert property (autoRestartOff [*2] |-> !powerSwitchGate)
		else $error("gate on in restart off");
	chk_double_top: assert property (freqDoubleReq == (limitSel.level == onoff_switch_pkg::LVL_MAX)
		&& limitSel.freqDouble == freqDoubleReq) else $error("double not tied to top level");
	// the sample edge may sit one or two clocks before the gate is seen high
	chk_start_sample: assert property ($rose(powerSwitchGate) |->
		($past(enableLineSensePin) || $past(enableLineSensePin, 2)) && maxDutyWindow) else $error("bad start");
	chk_blank_hold: assert property ($rose(powerSwitchGate) |=>
		(powerSwitchGate || supplyBelowLow || tempAboveTrip) [*3]) else $error("pulse cut in blanking");
	chk_limit_cut: assert property (powerSwitchGate [*6] ##0 switchOverLimit |=> !powerSwitchGate)
		else $error("gate on past limit");
	chk_level_step: assert property ($changed(limitSel.level) |=> $stable(limitSel.level) [*8])
		else $error("level stepped twice");
endmodule : onoff_switch_sva
bind onoff_switch_cycle_controller onoff_switch_sva i_onoff_switch_sva (.clk, .rst_b, .enableLineSensePin,
	.switchOverLimit, .supplyBelowLow, .tempAboveTrip, .powerSwitchGate, .limitSel, .freqDoubleReq,
	.maxDutyWindow, .autoRestartOff);

// >>> dv/fb_partner.sv
// Purpose: output feedback network driving the enable pin
// Assumes: each on clock adds charge, the load drains it
// Notes: openLoop holds enable high, noLoad holds it low
// ====
// partner
module fb_partner (
	input wire logic clk,
	input wire logic powerSwitchGate,
	input wire logic openLoop,
	input wire logic noLoad,
	output logic enableLineSensePin
);
	timeunit 1ns;
	timeprecision 1ns;
	int charge = 0;
	always @(posedge clk) begin
		charge <= powerSwitchGate ? charge + 2 : (charge > 0 ? charge - 1 : 0);
		enableLineSensePin <= #1 openLoop || (!noLoad && charge < 40);
	end
endmodule : fb_partner

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the switch cycle controller
// Assumes: 20 MHz clock, short restart off time
// Notes: 8192 cycle restart is too long to run; the checker only checks the gate stays off in restart off
// ====
// bench
`include "onoff_switch_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, rst_b = 1'h0, en, overLim = 1'h0, supLow = 1'h0, supHigh = 1'h1, tHi = 1'h0;
	logic tLo = 1'h1, lineOk = 1'h0, lineAbs = 1'h0, openLoop = 1'h0, noLoad = 1'h0, gate, fdr, mdw, aro;
	onoff_switch_pkg::limit_sel_t sel;
	int n_errors = 0, compares = 0;
	always #25 clk = ~clk;
	onoff_switch_cycle_controller #(.RESTART_OFF_CYCLES(200)) i_onoff_switch_cycle_controller (.clk, .rst_b,
		.enableLineSensePin(en), .switchOverLimit(overLim), .supplyBelowLow(supLow), .supplyAboveHigh(supHigh),
		.tempAboveTrip(tHi), .tempBelowRelease(tLo), .lineSenseAboveStart(lineOk), .lineResistorAbsent(lineAbs),
		.powerSwitchGate(gate), .limitSel(sel), .freqDoubleReq(fdr), .maxDutyWindow(mdw), .autoRestartOff(aro));
	fb_partner i_fb_partner (.clk, .powerSwitchGate(gate), .openLoop, .noLoad, .enableLineSensePin(en));
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : tick
	task automatic check(input string what, input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// a window of several half-rate cycles, so a run of skipped cycles cannot hide a pulse
	task automatic expect_pulses(input string what, input logic any);
		int p;
		logic last;
		p = 0;
		last = gate;
		repeat (1200) begin
			tick(1);
			p += int'(gate === 1'h1 && last === 1'h0);
			last = gate;
		end
		check(what, p != 0, any);
	endtask : expect_pulses
	task automatic wait_rise(output int w);
		logic last;
		w = 0;
		last = 1'h1;
		while (!(gate === 1'h1 && last === 1'h0)) begin
			last = gate;
			tick(1);
			w++;
			if (w > 300) begin
				n_errors++;
				tally_and_finish();
			end
		end
	endtask : wait_rise
	task automatic s_start();
		check("top level", sel.level === onoff_switch_pkg::LVL_MAX, 1'h1);
		check("double", fdr, 1'h1);
		expect_pulses("no line", 1'h0);
		lineOk = 1'h1;
		expect_pulses("line up", 1'h1);
		lineOk = 1'h0;
		expect_pulses("line ignored", 1'h1);
		lineOk = 1'h1;
	endtask : s_start
	task automatic s_limit();
		int w;
		openLoop = 1'h1;
		overLim = 1'h1;
		wait_rise(w);
		w = 0;
		while (gate === 1'h1 && w < 50) begin
			tick(1);
			w++;
		end
		check("limited width", w == 5, 1'h1);
		overLim = 1'h0;
		wait_rise(w);
		openLoop = 1'h0;
		noLoad = 1'h1;
		tick(10);
		check("cycle runs on", gate, 1'h1);
		noLoad = 1'h0;
	endtask : s_limit
	task automatic s_levels();
		int w;
		noLoad = 1'h1;
		tick(3000);
		check("low level", sel.level === onoff_switch_pkg::LVL_MIN, 1'h1);
		check("base rate", fdr, 1'h0);
		check("restart idle", aro, 1'h0);
		noLoad = 1'h0;
		openLoop = 1'h1;
		wait_rise(w);
		check("fast resample", w <= 80, 1'h1);
		tick(3000);
		check("level back", sel.level === onoff_switch_pkg::LVL_MAX, 1'h1);
		w = 0;
		while (mdw === 1'h1 && w < 200) begin
			tick(1);
			w++;
		end
		while (mdw !== 1'h1 && w < 400) begin
			tick(1);
			w++;
		end
		w = 0;
		while (mdw === 1'h1 && w < 200) begin
			tick(1);
			w++;
		end
		check("duty window", w == `MAXDUTY_CYC, 1'h1);
	endtask : s_levels
	task automatic s_lockouts();
		supLow = 1'h1;
		supHigh = 1'h0;
		expect_pulses("supply low", 1'h0);
		supLow = 1'h0;
		expect_pulses("supply between", 1'h0);
		supHigh = 1'h1;
		expect_pulses("supply back", 1'h1);
		tHi = 1'h1;
		tLo = 1'h0;
		expect_pulses("hot", 1'h0);
		tHi = 1'h0;
		expect_pulses("cooling", 1'h0);
		tLo = 1'h1;
		expect_pulses("cool", 1'h1);
		openLoop = 1'h0;
	endtask : s_lockouts
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_b = 1'h1;
		tick(3);
		s_start();
		s_limit();
		s_levels();
		s_lockouts();
		tally_and_finish();
	end
endmodule : tb_top
